/* apsel_regs.svh */
`ifndef APSEL_REGS_SVH
`define APSEL_REGS_SVH
`define APSEL_ADDR_DLY_EN     16'hfa26
`define APSEL_ADDR_DLY_SET    16'hfa27
`define APSEL_ADDR_PORT2_DIR  16'hff22
`define APSEL_ADDR_PIN_SEL    16'hff8f
`define APSEL_RST_DLY_EN      8'h00
`define APSEL_RST_DLY_SET     8'h20
`define APSEL_RST_PORT2_DIR   8'hff
`define APSEL_RST_PIN_SEL     8'h08
`define APSEL_PIN_SEL_MAX     4'h8
`define APSEL_DLY_EN_BIT      7
`define APSEL_DLY_CODE_LSB    4
`define APSEL_DLY_CODE_MSB    6
`define APSEL_DLY_STEP_NS     2
`endif

/* apsel_pkg.sv */
package apsel_pkg;
  typedef enum logic [1:0]
  {
    APSEL_DIGITAL_IN,
    APSEL_DIGITAL_OUT,
    APSEL_ANALOG_IDLE,
    APSEL_ANALOG_BAD
  } apsel_mode_e;
  typedef logic [7:0] apsel_byte_t;
endpackage : apsel_pkg

/* apsel_pin_select.sv */
`include "apsel_regs.svh"
// Overview of operation
// - Pin-count code 0 all analog; each step to 8 frees one low pin; above prohibited.
// - Pin-select register resets to 08H, all pins digital.
// - Pin-select write inserts one wait cycle; avoid with peripheral clock stopped.
// - Delay-enable holds bit 7 only, resets 00H.
// - Delay code bits 6..4 give 2ns times code plus one; reset 20H.
// - Direction register one bit per pin, 1 input, resets FFH.
// - Analog needs direction 1; output latch then ignored.
// - Analog input feeds the selecting converter; both or output prohibited.
// - Digital pin uses direction bit alone for input or output.
// - Pin-select takes single-bit and whole-byte writes.
module apsel_pin_select
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [15:0] addr,
  input  wire logic        wrEn,
  input  wire logic        bitWr,
  input  wire logic [2:0]  bitIdx,
  input  wire logic [7:0]  wrData,
  input  wire logic        rdEn,
  output logic      [7:0]  rdData,
  output logic             waitReq,
  input  wire logic [7:0]  portLatch,
  input  wire logic [7:0]  sarSelect,
  input  wire logic [7:0]  sigmaSelect,
  output logic      [7:0]  pinAnalog,
  output logic      [7:0]  pinOutEn,
  output logic      [7:0]  pinOut,
  output logic      [7:0]  sarInputEn,
  output logic      [7:0]  sigmaInputEn,
  output logic      [7:0]  pinConflict,
  output logic             delaySetEnable,
  output logic      [2:0]  delayCode,
  output logic      [4:0]  delayNs
);
  // Reset values kept as named constants: a literal cannot be bit-selected
  localparam logic [7:0] RstSel = `APSEL_RST_PIN_SEL;
  localparam logic [7:0] RstDir = `APSEL_RST_PORT2_DIR;
  localparam logic [7:0] RstEn  = `APSEL_RST_DLY_EN;
  localparam logic [7:0] RstDly = `APSEL_RST_DLY_SET;
  localparam logic [3:0] SelMax = `APSEL_PIN_SEL_MAX;
  localparam int         EnBit  = `APSEL_DLY_EN_BIT;
  localparam int         CodeLo = `APSEL_DLY_CODE_LSB;
  localparam int         CodeHi = `APSEL_DLY_CODE_MSB;
  localparam int         StepNs = `APSEL_DLY_STEP_NS;

  logic [3:0] analogPinCount;
  apsel_pkg::apsel_byte_t port2Direction;
  logic       waitPending;
  logic [7:0] pinOutReg;

  wire hitSel = addr == `APSEL_ADDR_PIN_SEL;
  wire hitDir = addr == `APSEL_ADDR_PORT2_DIR;
  wire hitEn  = addr == `APSEL_ADDR_DLY_EN;
  wire hitDly = addr == `APSEL_ADDR_DLY_SET;

  // Merge one bit into the old value for bit writes
  function automatic logic [7:0] mergeWrite(input logic [7:0] oldVal,
                                            input logic       isBit,
                                            input logic [2:0] idx,
                                            input logic [7:0] newVal);
    logic [7:0] r;
    r = oldVal;
    if (isBit)
      r[idx] = newVal[idx];
    else
      r = newVal;
    return r;
  endfunction : mergeWrite

  // One mode per pin; routing and the conflict flag both derive from it
  function automatic apsel_pkg::apsel_mode_e pinMode(input logic ana,
                                                     input logic dirIn);
    apsel_pkg::apsel_mode_e m;
    if (!ana)
      m = dirIn ? apsel_pkg::APSEL_DIGITAL_IN : apsel_pkg::APSEL_DIGITAL_OUT;
    else
      m = dirIn ? apsel_pkg::APSEL_ANALOG_IDLE : apsel_pkg::APSEL_ANALOG_BAD;
    return m;
  endfunction : pinMode

  wire [7:0] selMerged = mergeWrite({4'h0, analogPinCount}, bitWr, bitIdx,
                                    wrData);
  wire [7:0] dirMerged = mergeWrite(port2Direction, bitWr, bitIdx, wrData);
  wire       selLegal  = selMerged[3:0] <= SelMax;

  // Decoded write strobes; a pin-select write in its wait cycle, the cycle after the write, is ignored
  wire wrSel    = wrEn && hitSel && !waitPending;
  wire wrDir    = wrEn && hitDir;
  wire wrDlyEn  = wrEn && hitEn;
  wire wrDlySet = wrEn && hitDly;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      waitPending <= 1'b0;
    else
      waitPending <= wrSel;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      analogPinCount <= RstSel[3:0];
    else if (wrSel && selLegal)
      analogPinCount <= selMerged[3:0];
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      port2Direction <= RstDir;
    else if (wrDir)
      port2Direction <= dirMerged;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      delaySetEnable <= RstEn[EnBit];
    else if (wrDlyEn)
      delaySetEnable <= wrData[EnBit];
  end

  // code field only
  // Not gated by the enable bit: keeping that order is software's duty
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      delayCode <= RstDly[CodeHi:CodeLo];
    else if (wrDlySet)
      delayCode <= wrData[CodeHi:CodeLo];
  end

  // Wait is raised combinationally in the first cycle of a pin-select write
  assign waitReq = wrSel;

  wire [7:0] rdSel = {4'h0, analogPinCount};
  wire [7:0] rdEnR = {delaySetEnable, 7'h00};
  wire [7:0] rdDly = {1'b0, delayCode, 4'h0};
  wire [7:0] rdMux = !rdEn  ? 8'h00 :
                     hitSel ? rdSel :
                     hitDir ? port2Direction :
                     hitEn  ? rdEnR :
                     hitDly ? rdDly : 8'h00;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rdData <= 8'h00;
    else
      rdData <= rdMux;
  end

  // Latch copy is registered so the pin data comes from a flip-flop
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      pinOutReg <= 8'h00;
    else
      pinOutReg <= portLatch;
  end

  assign delayNs = 5'(StepNs * ({2'b00, delayCode} + 5'd1));

  genvar i;
  generate
    for (i = 0; i < 8; i++)
    begin : g_pin
      wire isAnalog = 4'(i) >= analogPinCount;
      apsel_pkg::apsel_mode_e pinSt;
      assign pinSt = pinMode(isAnalog, port2Direction[i]);
      wire anaIn    = pinSt == apsel_pkg::APSEL_ANALOG_IDLE;
      assign pinAnalog[i]    = isAnalog;
      assign pinOutEn[i]     = pinSt == apsel_pkg::APSEL_DIGITAL_OUT;
      assign pinOut[i]       = pinOutEn[i] ? pinOutReg[i] : 1'b0;
      assign sarInputEn[i]   = anaIn && sarSelect[i] && !sigmaSelect[i];
      assign sigmaInputEn[i] = anaIn && sigmaSelect[i] && !sarSelect[i];
      assign pinConflict[i]  = (sarSelect[i] || sigmaSelect[i]) &&
                               (!anaIn || (sarSelect[i] && sigmaSelect[i]));
    end
  endgenerate
endmodule : apsel_pin_select

/* apsel_chk.sv */
module apsel_chk
(
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic [15:0] addr,
  input wire logic        wrEn,
  input wire logic [7:0]  wrData,
  input wire logic        waitReq,
  input wire logic [7:0]  pinAnalog,
  input wire logic [7:0]  pinOutEn,
  input wire logic [7:0]  sarInputEn,
  input wire logic [7:0]  sigmaInputEn,
  input wire logic        delaySetEnable,
  input wire logic [2:0]  delayCode,
  input wire logic [4:0]  delayNs
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_wait_sel_only: assert property (waitReq |-> wrEn && addr == 16'hff8f)
    else $error("stray wait");
  a_wait_one_cycle: assert property (waitReq |=> !waitReq)
    else $error("long wait");
  a_delay_ns: assert property (delayNs == {1'b0, delayCode, 1'b0} + 5'h02)
    else $error("bad delay ns");
  a_out_digital: assert property ((pinOutEn & pinAnalog) == 8'h00)
    else $error("analog pin driven");
  a_sar_analog: assert property ((sarInputEn & ~pinAnalog) == 8'h00)
    else $error("digital pin routed");
  a_route_single: assert property ((sarInputEn & sigmaInputEn) == 8'h00)
    else $error("double route");
  a_enable_write: assert property (wrEn && addr == 16'hfa26
    |=> delaySetEnable == $past(wrData[7])) else $error("enable lost");
  a_code_write: assert property (wrEn && addr == 16'hfa27
    |=> delayCode == $past(wrData[6:4])) else $error("code lost");
endmodule : apsel_chk
bind apsel_pin_select apsel_chk u_apsel_chk (.*);

/* apsel_conv_model.sv */
module apsel_conv_model
(
  input wire logic [7:0] pinAnalog,
  input wire logic [2:0] chan,
  input wire logic       useSigma,
  output logic     [7:0] sarSelect,
  output logic     [7:0] sigmaSelect
);
  timeunit 1ns;
  timeprecision 1ps;
  assign sarSelect = useSigma ? 8'h00 : pinAnalog & (8'h01 << chan);
  assign sigmaSelect = useSigma ? pinAnalog & (8'h01 << chan) : 8'h00;
endmodule : apsel_conv_model

/* tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, rst = 1, wrEn = 0, bitWr = 0, rdEn = 0, useSigma = 0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wrData = 8'h00, portLatch = 8'haa, rdData, pinAnalog, pinOut;
  logic [7:0] pinOutEn, sarSelect, sigmaSelect, sarInputEn, sigmaInputEn;
  logic [7:0] pinConflict;
  logic [2:0] bitIdx = 3'h0, chan = 3'h2, delayCode;
  logic [4:0] delayNs;
  logic waitReq, delaySetEnable;
  int badCount = 0, checked = 0;
  apsel_pin_select u_apsel_pin_select (.clk_sys, .rst, .addr, .wrEn, .bitWr,
    .bitIdx, .wrData, .rdEn, .rdData, .waitReq, .portLatch, .sarSelect,
    .sigmaSelect, .pinAnalog, .pinOutEn, .pinOut, .sarInputEn,
    .sigmaInputEn, .pinConflict, .delaySetEnable, .delayCode, .delayNs);
  apsel_conv_model u_apsel_conv_model (.pinAnalog, .chan, .useSigma,
    .sarSelect, .sigmaSelect);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      badCount++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask : chk
  // held two cycles so a pin-select write rides out its wait cycle
  task automatic wr(input logic [15:0] a, input logic [7:0] d,
    input logic b = 1'b0, input logic [2:0] i = 3'h0);
    @(posedge clk_sys);
    #1 {addr, wrData, bitWr, bitIdx, wrEn} = {a, d, b, i, 1'b1};
    repeat (2) @(posedge clk_sys);
    #1 wrEn = 0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    #1 {addr, rdEn} = {a, 1'b1};
    @(posedge clk_sys);
    #1 rdEn = 0;
    chk(rdData, exp);
  endtask : rd
  task automatic completeRun;
    if (badCount == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : completeRun
  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end
  initial
  begin
    #20000;
    badCount++;
    completeRun();
  end
  initial
  begin
    repeat (5) @(posedge clk_sys);
    #1 rst = 0;
    rd(16'hff8f, 8'h08);
    rd(16'hfa26, 8'h00);
    rd(16'hfa27, 8'h20);
    rd(16'hff22, 8'hff);
    chk(pinAnalog, 8'h00);
    for (int n = 0; n <= 8; n++)
    begin
      wr(16'hff8f, 8'(n));
      chk(pinAnalog, 8'hff << n);
    end
    wr(16'hff8f, 8'h09);
    rd(16'hff8f, 8'h08);
    wr(16'hff8f, 8'hf3);
    rd(16'hff8f, 8'h03);
    wr(16'hff8f, 8'h00, 1'b1, 3'h1);
    rd(16'hff8f, 8'h01);
    wr(16'hff8f, 8'h08);
    wr(16'hff22, 8'h0f);
    chk(pinOutEn, 8'hf0);
    chk(pinOut, 8'ha0);
    wr(16'hff22, 8'hff);
    wr(16'hff8f, 8'h00);
    chk(sarInputEn, 8'h04);
    chk(pinOutEn, 8'h00);
    #1 useSigma = 1;
    #1 chk(sigmaInputEn, 8'h04);
    chk(pinConflict, 8'h00);
    wr(16'hff22, 8'hfb);
    chk(sigmaInputEn, 8'h00);
    chk(pinConflict, 8'h04);
    wr(16'hfa26, 8'hff);
    rd(16'hfa26, 8'h80);
    wr(16'hfa27, 8'hff);
    rd(16'hfa27, 8'h70);
    chk({3'h0, delayNs}, 8'h10);
    rd(16'h0000, 8'h00);
    completeRun();
  end
endmodule : tb_top
